// File: design/tmseq_map.svh
// Register map, field positions, reset values and timing counts of the temperature sequencer
`ifndef TMSEQ_MAP_SVH
`define TMSEQ_MAP_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define TM_REG_CONFIG 8'h00
`define TM_REG_IDEAL 8'h04
`define TM_REG_DELAY 8'h08
`define TM_REG_STATUS 8'h0c
`define TM_REG_DATA_LOCAL 8'h10
`define TM_REG_DATA_REMOTE1 8'h14
`define TM_REG_DATA_REMOTE2 8'h18

// ************************************************************
// Field positions
// ************************************************************
`define TM_CFG_LOCAL_EN_BIT 0
`define TM_CFG_REMOTE1_EN_BIT 1
`define TM_CFG_REMOTE2_EN_BIT 2
`define TM_CFG_RC_EN_BIT 3
`define TM_CFG_REF_BUF_BIT 4
`define TM_DLY_EN_BIT 0
`define TM_DLY_CODE_LSB 1
`define TM_DLY_CODE_MSB 3

// ************************************************************
// Reset values
// ************************************************************
`define TM_CFG_RST 5'h07
`define TM_IDEAL_RST 8'h00
`define TM_DLY_RST 4'h0

// ************************************************************
// Timing and arithmetic constants
// ************************************************************
`define TM_CLK_FREQ_KHZ 100000
`define TM_LOCAL_SLOT_MS 15
`define TM_REMOTE_SLOT_MS 44
`define TM_REMOTE_RC_SLOT_MS 93
`define TM_DELAY_MIN_MULT 9'h020
`define TM_IDEAL_SCALE 10'sh12c

`endif

// File: design/tmseq_pkg.sv
// Types shared by the temperature sequencer modules
package tmseq_pkg;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        TMSEQ_LOAD = 4'b0001,
        TMSEQ_CONV = 4'b0010,
        TMSEQ_ADV = 4'b0100,
        TMSEQ_WAIT = 4'b1000
    } tmseq_state_e;

    // Sensor index: 0 local, 1 remote 1, 2 remote 2, 3 none
    typedef logic [1:0] tmseq_sensor_t;

    // Twelve-bit two's-complement temperature word
    typedef logic signed [11:0] tmseq_temp_t;

endpackage : tmseq_pkg

// File: design/tmseq_corr_if.sv
// Carrier between the sequencer and its ideality correction stage
`timescale 1ns/1ns
interface tmseq_corr_if;
    logic in_valid;
    tmseq_pkg::tmseq_sensor_t in_sel;
    tmseq_pkg::tmseq_temp_t in_raw;
    logic [7:0] adj;
    logic out_valid;
    tmseq_pkg::tmseq_sensor_t out_sel;
    tmseq_pkg::tmseq_temp_t out_temp;

    modport src (output in_valid, output in_sel, output in_raw, output adj,
                 input out_valid, input out_sel, input out_temp);
    modport corr (input in_valid, input in_sel, input in_raw, input adj,
                  output out_valid, output out_sel, output out_temp);
endinterface : tmseq_corr_if

// File: design/tmseq_ideal_corr.sv
// Ideality correction stage: rescales remote readings by the signed adjustment
`timescale 1ns/1ns
`include "tmseq_map.svh"
module tmseq_ideal_corr (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Raw reading in, corrected word out
    tmseq_corr_if.corr cif
);

    // ************************************************************
    // Arithmetic
    // ************************************************************
    localparam logic signed [21:0] SCALE_W = 22'(`TM_IDEAL_SCALE);
    logic signed [9:0] divisor;
    logic signed [21:0] prod;
    logic signed [21:0] quot;
    wire is_remote = (cif.in_sel != 2'd0);
    tmseq_pkg::tmseq_temp_t sat;
    tmseq_pkg::tmseq_temp_t result;

    // Raw is taken at the trimmed ideality; scale by (300 - adj) / 300
    assign divisor = `TM_IDEAL_SCALE - {{2{cif.adj[7]}}, cif.adj}; // RULE2 RULE3
    assign prod = 22'(cif.in_raw * divisor); // RULE3
    assign quot = prod / SCALE_W; // RULE3
    // Clip to the twelve-bit word rather than wrap on extreme adjustments
    assign sat = (quot > 22'sd2047) ? 12'sh7ff :
                 (quot < -22'sd2048) ? 12'sh800 : quot[11:0]; // RULE5 RULE15
    // The local sensor is not a remote diode and bypasses the correction
    assign result = is_remote ? sat : cif.in_raw;

    // Output register, one cycle of latency
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cif.out_valid <= 1'b0;
            cif.out_sel <= 2'd0;
            cif.out_temp <= 12'sh000;
        end else begin
            cif.out_valid <= cif.in_valid;
            cif.out_sel <= cif.in_sel;
            cif.out_temp <= result;
        end
    end

endmodule : tmseq_ideal_corr

// File: design/tmseq_top.sv
// Background temperature monitor sequencer with register port
// Contract
// RULE1 - After reset the ideality adjustment is zero, giving the trimmed ideality of 1.008.
// RULE2 - The ideality adjustment is an 8-bit two's-complement value from 0x80 (-128) to 0x7F (+127).
// RULE3 - Remote readings use ideality 1.008 * 300 / (300 - adjustment).
// RULE4 - Series-resistance cancellation runs on remote slots only while its enable bit is set.
// RULE5 - Every temperature result is a 12-bit word.
// RULE6 - A finished result goes to its sensor's data register, held off while that register is shifted out.
// RULE7 - Local sensor alone gives a 15 ms cycle; programmable delay spans 0.48 s to 3.84 s. Here delay codes 4 to 7 all give 7.68 s.
// RULE8 - One remote sensor alone gives 44 ms without cancellation and 93 ms with it.
// RULE9 - One remote plus local gives 59 ms without cancellation and 108 ms with it.
// RULE10 - Two remote sensors without local give 88 ms without cancellation and 186 ms with it.
// RULE11 - All three sensors give 103 ms without cancellation and 201 ms with it.
// RULE12 - Software clears the reference buffer bit for an external reference and sets it for the internal one.
// RULE13 - Each sensor has its own enable bit and a disabled sensor is not converted.
// RULE14 - Monitoring runs continuously and each finished cycle starts the next one.
// RULE15 - Results are two's complement, +150 degrees reading as 010010110000.
// RULE16 - Enable and cancellation changes take effect at the start of the next cycle.
`timescale 1ns/1ns
`include "tmseq_map.svh"
module tmseq_top #(
    parameter int unsigned LOCAL_SLOT_CYC = `TM_LOCAL_SLOT_MS * `TM_CLK_FREQ_KHZ,
    parameter int unsigned REMOTE_SLOT_CYC = `TM_REMOTE_SLOT_MS * `TM_CLK_FREQ_KHZ,
    parameter int unsigned REMOTE_RC_SLOT_CYC = `TM_REMOTE_RC_SLOT_MS * `TM_CLK_FREQ_KHZ
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // Front end raw readings
    input wire logic RAW_VALID,
    input wire logic [11:0] RAW_TEMP,
    // Serial transfer of a data register in progress
    input wire logic XFER_BUSY,
    input wire logic [1:0] XFER_SEL,
    // Front end control
    output logic [2:0] SENSOR_SEL,
    output logic CONV_START,
    output logic RC_ACTIVE,
    output logic CYCLE_DONE,
    output logic ADC_REF_BUF_EN
);

    // ************************************************************
    // Decoding helpers
    // ************************************************************

    // First enabled sensor at or above the given index, 3 when none
    function automatic tmseq_pkg::tmseq_sensor_t tmseq_next_sensor(
        input tmseq_pkg::tmseq_sensor_t from, input logic [2:0] en);
        tmseq_pkg::tmseq_sensor_t r;
        r = 2'd3;
        for (int i = 2; i >= 0; i--) begin
            if (en[i] && (2'(i) >= from)) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction : tmseq_next_sensor

    // Slot length minus one for a sensor under the given cancellation setting
    function automatic logic [31:0] tmseq_slot_last(
        input tmseq_pkg::tmseq_sensor_t s, input logic rc);
        logic [31:0] n;
        n = (s == 2'd0) ? 32'(LOCAL_SLOT_CYC) :
            (rc ? 32'(REMOTE_RC_SLOT_CYC) : 32'(REMOTE_SLOT_CYC));
        return n - 32'h1;
    endfunction : tmseq_slot_last

    // ************************************************************
    // Register port
    // ************************************************************
    logic [4:0] cfg_reg;
    logic [7:0] adj_reg;
    logic [3:0] dly_reg;
    logic [11:0] data_reg [3];
    logic [2:0] pend_reg;
    logic [11:0] pend_val_reg [3];
    logic [7:0] done_cnt_reg;
    tmseq_pkg::tmseq_state_e state_reg;
    tmseq_pkg::tmseq_sensor_t sel_reg;

    wire wr_cfg = WR && (ADDR == `TM_REG_CONFIG);
    wire wr_adj = WR && (ADDR == `TM_REG_IDEAL);
    wire wr_dly = WR && (ADDR == `TM_REG_DELAY);
    wire converting = (state_reg == tmseq_pkg::TMSEQ_CONV);
    wire waiting = (state_reg == tmseq_pkg::TMSEQ_WAIT);
    logic [15:0] status_word;
    logic [15:0] rd_mux;

    // Status shows the live sequencer position and results still held off
    assign status_word = {done_cnt_reg, pend_reg, waiting, converting, SENSOR_SEL};
    // Unmapped addresses read as zero
    assign rd_mux = (ADDR == `TM_REG_CONFIG) ? {11'h000, cfg_reg} :
                    (ADDR == `TM_REG_IDEAL) ? {8'h00, adj_reg} :
                    (ADDR == `TM_REG_DELAY) ? {12'h000, dly_reg} :
                    (ADDR == `TM_REG_STATUS) ? status_word :
                    (ADDR == `TM_REG_DATA_LOCAL) ? {4'h0, data_reg[0]} :
                    (ADDR == `TM_REG_DATA_REMOTE1) ? {4'h0, data_reg[1]} :
                    (ADDR == `TM_REG_DATA_REMOTE2) ? {4'h0, data_reg[2]} : 16'h0000;

    // Writable control registers
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            cfg_reg <= `TM_CFG_RST;
            adj_reg <= `TM_IDEAL_RST; // RULE1
            dly_reg <= `TM_DLY_RST;
        end else begin
            if (wr_cfg) begin
                cfg_reg <= WDATA[4:0]; // RULE13
            end
            if (wr_adj) begin
                adj_reg <= WDATA[7:0]; // RULE2
            end
            if (wr_dly) begin
                dly_reg <= WDATA[3:0];
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            RDATA <= 16'h0000;
            ADC_REF_BUF_EN <= 1'b0;
        end else begin
            RDATA <= RD ? rd_mux : 16'h0000;
            // Software owns the choice of reference; the block only drives the buffer
            ADC_REF_BUF_EN <= cfg_reg[`TM_CFG_REF_BUF_BIT]; // RULE12
        end
    end

    // ************************************************************
    // Monitoring sequencer
    // ************************************************************
    logic [2:0] act_en_reg;
    logic act_rc_reg;
    logic [31:0] slot_cnt_reg;
    logic [31:0] cyc_cnt_reg;
    logic [31:0] cyc_len_reg;
    logic [31:0] wait_cnt_reg;
    logic [8:0] rep_reg;

    wire [2:0] cfg_en = cfg_reg[2:0];
    wire cfg_rc = cfg_reg[`TM_CFG_RC_EN_BIT];
    wire tmseq_pkg::tmseq_sensor_t first_sel = tmseq_next_sensor(2'd0, cfg_en);
    wire tmseq_pkg::tmseq_sensor_t adv_sel = tmseq_next_sensor(2'(sel_reg + 2'd1), act_en_reg);
    wire dly_en = dly_reg[`TM_DLY_EN_BIT];
    wire [8:0] dly_mult = `TM_DELAY_MIN_MULT << dly_reg[`TM_DLY_CODE_MSB:`TM_DLY_CODE_LSB];
    logic [2:0] sel_onehot;

    // One-hot select of the sensor in its slot
    assign sel_onehot = (adv_sel == 2'd3) ? 3'b000 : (3'b001 << adv_sel);

    // State and counters; config is frozen for the whole cycle
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            state_reg <= tmseq_pkg::TMSEQ_LOAD;
            sel_reg <= 2'd0;
            act_en_reg <= 3'b000;
            act_rc_reg <= 1'b0;
            slot_cnt_reg <= 32'h0;
            cyc_cnt_reg <= 32'h0;
            cyc_len_reg <= 32'h0;
            wait_cnt_reg <= 32'h0;
            rep_reg <= 9'h000;
            done_cnt_reg <= 8'h00;
            SENSOR_SEL <= 3'b000;
            CONV_START <= 1'b0;
            RC_ACTIVE <= 1'b0;
            CYCLE_DONE <= 1'b0;
        end else begin
            CONV_START <= 1'b0;
            CYCLE_DONE <= 1'b0;
            unique case (state_reg)
                tmseq_pkg::TMSEQ_LOAD: begin
                    act_en_reg <= cfg_en; // RULE16
                    act_rc_reg <= cfg_rc; // RULE16
                    cyc_cnt_reg <= 32'h1;
                    // With nothing enabled the sequencer idles here
                    if (first_sel != 2'd3) begin // RULE13
                        sel_reg <= first_sel;
                        slot_cnt_reg <= tmseq_slot_last(first_sel, cfg_rc); // RULE7 RULE8
                        SENSOR_SEL <= 3'b001 << first_sel;
                        RC_ACTIVE <= cfg_rc && (first_sel != 2'd0); // RULE4
                        CONV_START <= 1'b1;
                        state_reg <= tmseq_pkg::TMSEQ_CONV;
                    end
                end
                tmseq_pkg::TMSEQ_CONV: begin
                    cyc_cnt_reg <= cyc_cnt_reg + 32'h1;
                    if (slot_cnt_reg == 32'h0) begin
                        state_reg <= tmseq_pkg::TMSEQ_ADV;
                    end else begin
                        slot_cnt_reg <= slot_cnt_reg - 32'h1;
                    end
                end
                tmseq_pkg::TMSEQ_ADV: begin
                    cyc_cnt_reg <= cyc_cnt_reg + 32'h1;
                    SENSOR_SEL <= sel_onehot;
                    RC_ACTIVE <= act_rc_reg && (adv_sel != 2'd3); // RULE4
                    // Slots add up: each enabled sensor, local or remote, adds its own slot
                    if (adv_sel != 2'd3) begin // RULE9 RULE10 RULE11
                        sel_reg <= adv_sel;
                        slot_cnt_reg <= tmseq_slot_last(adv_sel, act_rc_reg); // RULE8
                        CONV_START <= 1'b1;
                        state_reg <= tmseq_pkg::TMSEQ_CONV;
                    end else begin
                        CYCLE_DONE <= 1'b1;
                        done_cnt_reg <= done_cnt_reg + 8'h01;
                        // The count has not yet taken in this closing clock, so add it
                        cyc_len_reg <= cyc_cnt_reg + 32'h1;
                        if (dly_en) begin
                            // Period becomes mult times the cycle: wait mult-1 cycles more
                            rep_reg <= dly_mult - 9'h001; // RULE7
                            wait_cnt_reg <= cyc_cnt_reg + 32'h1;
                            state_reg <= tmseq_pkg::TMSEQ_WAIT;
                        end else begin
                            state_reg <= tmseq_pkg::TMSEQ_LOAD; // RULE14
                        end
                    end
                end
                tmseq_pkg::TMSEQ_WAIT: begin
                    if (wait_cnt_reg > 32'h1) begin
                        wait_cnt_reg <= wait_cnt_reg - 32'h1;
                    end else if (rep_reg > 9'h001) begin
                        rep_reg <= rep_reg - 9'h001;
                        wait_cnt_reg <= cyc_len_reg;
                    end else begin
                        state_reg <= tmseq_pkg::TMSEQ_LOAD; // RULE14
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Correction stage
    // ************************************************************
    tmseq_corr_if cif ();

    // Raw words only count while a real slot is converting
    assign cif.in_valid = RAW_VALID && converting;
    assign cif.in_sel = sel_reg;
    assign cif.in_raw = RAW_TEMP;
    assign cif.adj = adj_reg; // RULE3

    tmseq_ideal_corr u_corr (
        .clk(CLK_SYS),
        .rst_n(NRST),
        .cif(cif)
    );

    // ************************************************************
    // Result posting
    // ************************************************************
    // A result is parked until its register is free of the serial transfer.
    // A newer result replaces a parked one, so the register never goes stale.
    for (genvar g = 0; g < 3; g++) begin : g_post
        wire hit = cif.out_valid && (cif.out_sel == 2'(g));
        wire blocked = XFER_BUSY && (XFER_SEL == 2'(g));
        wire commit = pend_reg[g] && !blocked;

        always_ff @(posedge CLK_SYS) begin
            if (!NRST) begin
                pend_reg[g] <= 1'b0;
                pend_val_reg[g] <= 12'h000;
                data_reg[g] <= 12'h000;
            end else begin
                if (hit) begin
                    pend_reg[g] <= 1'b1;
                    pend_val_reg[g] <= cif.out_temp; // RULE5
                end else if (commit) begin
                    pend_reg[g] <= 1'b0;
                end
                if (commit) begin
                    data_reg[g] <= pend_val_reg[g]; // RULE6 RULE15
                end
            end
        end
    end

endmodule : tmseq_top

// File: tb/tmseq_assertions.sv
// Port-level assertions of the temperature sequencer
`timescale 1ns/1ns
module tmseq_assertions #(
    parameter int unsigned LOCAL_SLOT_CYC = 4,
    parameter int unsigned REMOTE_SLOT_CYC = 6,
    parameter int unsigned REMOTE_RC_SLOT_CYC = 9
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    // Front end control
    input wire logic [2:0] SENSOR_SEL,
    input wire logic CONV_START,
    input wire logic RC_ACTIVE,
    input wire logic CYCLE_DONE,
    input wire logic ADC_REF_BUF_EN
);
    logic [2:0] sel_last_reg;
    logic [15:0] run_reg;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    // Samples the selection has stood; judged only when it changes, so no slot length is guessed
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            sel_last_reg <= 3'h0;
            run_reg <= 16'h0000;
        end else begin
            sel_last_reg <= SENSOR_SEL;
            run_reg <= (SENSOR_SEL != sel_last_reg) ? 16'h0001 : run_reg + 16'h0001;
        end
    end
    // ************************************************************
    // Assertions
    // ************************************************************
    a_done_one_pulse: assert property (CYCLE_DONE |=> !CYCLE_DONE)
        else $error("cycle done pulse longer than one clock");
    a_start_one_pulse: assert property (CONV_START |=> !CONV_START)
        else $error("slot start pulse longer than one clock");
    a_start_one_sensor: assert property (CONV_START |-> $onehot(SENSOR_SEL))
        else $error("slot started without exactly one sensor");
    a_sel_at_most_one: assert property ($onehot0(SENSOR_SEL))
        else $error("several sensors selected at once");
    a_rc_remote_only: assert property (RC_ACTIVE |-> (SENSOR_SEL == 3'b010 || SENSOR_SEL == 3'b100))
        else $error("cancellation active outside a remote slot");
    a_local_slot_len: assert property ((sel_last_reg == 3'b001 && SENSOR_SEL != 3'b001) |->
        run_reg == LOCAL_SLOT_CYC + 1) else $error("local slot length wrong");
    a_remote_slot_len: assert property ((sel_last_reg[2:1] != 2'b00 && SENSOR_SEL != sel_last_reg)
        |-> run_reg == ($past(RC_ACTIVE) ? REMOTE_RC_SLOT_CYC + 1 : REMOTE_SLOT_CYC + 1))
        else $error("remote slot length wrong");
    a_rdata_quiet: assert property (!RD |=> RDATA == 16'h0000)
        else $error("read data outside the read answer cycle");
    a_ref_buf_lag: assert property ((WR && ADDR == 8'h00 ##1 !(WR && ADDR == 8'h00))
        |=> ADC_REF_BUF_EN == $past(WDATA[4], 2)) else $error("reference buffer enable wrong");
endmodule : tmseq_assertions

bind tmseq_top tmseq_assertions #(.LOCAL_SLOT_CYC(LOCAL_SLOT_CYC),
    .REMOTE_SLOT_CYC(REMOTE_SLOT_CYC), .REMOTE_RC_SLOT_CYC(REMOTE_RC_SLOT_CYC)) u_tmseq_chk (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SENSOR_SEL(SENSOR_SEL), .CONV_START(CONV_START), .RC_ACTIVE(RC_ACTIVE),
    .CYCLE_DONE(CYCLE_DONE), .ADC_REF_BUF_EN(ADC_REF_BUF_EN));

// File: tb/tmseq_tb_top.sv
// Self-checking testbench of the temperature sequencer
`timescale 1ns/1ns
module tmseq_tb_top;
    // Short slots keep a monitoring cycle to a few dozen clocks
    localparam int LOC = 4;
    localparam int REM = 6;
    localparam int REMRC = 9;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic raw_valid = 1'b0;
    logic [11:0] raw_temp = 12'h000;
    logic xfer_busy = 1'b0;
    logic [1:0] xfer_sel = 2'h0;
    logic [15:0] rdata;
    logic [2:0] sensor_sel, seen;
    logic conv_start, rc_active, cycle_done, ref_buf_en, rc_seen;
    int miscompares = 0;
    int total_checks = 0;
    int starts = 0;
    int prev_len = 0;

    tmseq_top #(.LOCAL_SLOT_CYC(LOC), .REMOTE_SLOT_CYC(REM), .REMOTE_RC_SLOT_CYC(REMRC)) dut (
        .CLK_SYS(clk_sys), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RAW_VALID(raw_valid), .RAW_TEMP(raw_temp), .XFER_BUSY(xfer_busy),
        .XFER_SEL(xfer_sel), .SENSOR_SEL(sensor_sel), .CONV_START(conv_start),
        .RC_ACTIVE(rc_active), .CYCLE_DONE(cycle_done), .ADC_REF_BUF_EN(ref_buf_en));

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so look there
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_reg

    // Counts clocks up to the next cycle end, noting what the front end saw meanwhile
    task automatic span(output int n);
        n = 0;
        starts = 0;
        seen = 3'h0;
        rc_seen = 1'b0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
            starts += int'(conv_start === 1'b1);
            seen |= sensor_sel;
            rc_seen |= rc_active;
        end while (cycle_done !== 1'b1 && n < 6000);
        if (n >= 6000) chk(16'h0000, 16'h0001);
    endtask : span

    // Waits for a slot of sensor s, then hands it one raw reading
    task automatic feed(input logic [2:0] s, input logic [11:0] v);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (!(conv_start === 1'b1 && sensor_sel === s) && n < 2000);
        if (n >= 2000) chk(16'h0000, 16'h0001);
        @(posedge clk_sys);
        raw_valid <= 1'b1;
        raw_temp <= v;
        @(posedge clk_sys);
        raw_valid <= 1'b0;
    endtask : feed

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs;
        rd_reg(8'h00, 16'h0007);
        rd_reg(8'h04, 16'h0000);
        wr_reg(8'h04, 16'h007f);
        rd_reg(8'h04, 16'h007f);
        wr_reg(8'h04, 16'h0080);
        rd_reg(8'h04, 16'h0080);
        rd_reg(8'h20, 16'h0000);
        wr_reg(8'h00, 16'h0017);
        repeat (2) @(posedge clk_sys);
        #1 chk({15'h0, ref_buf_en}, 16'h0001);
        wr_reg(8'h00, 16'h0007);
        repeat (2) @(posedge clk_sys);
        #1 chk({15'h0, ref_buf_en}, 16'h0000);
    endtask : t_regs

    // A write in mid-cycle leaves that cycle alone; the next one follows the new setting
    task automatic t_cycle(input logic [15:0] c, input logic [15:0] d);
        int m, n, r, exp;
        r = c[3] ? REMRC : REM;
        exp = 1 + (c[0] ? LOC + 1 : 0) + (c[1] ? r + 1 : 0) + (c[2] ? r + 1 : 0);
        if (d[0]) exp = exp * (32 << d[3:1]);
        span(m);
        wr_reg(8'h00, c);
        wr_reg(8'h08, d);
        span(m);
        if (prev_len != 0) chk(16'(m + 4), 16'(prev_len));
        // The first wait after a delay write still scales the old cycle, so let it pass
        if (d[0]) span(n);
        span(n);
        chk(16'(n), 16'(exp));
        chk(16'(starts), 16'($countones(c[2:0])));
        chk({13'h0, seen}, {13'h0, c[2:0]});
        chk({15'h0, rc_seen}, {15'h0, c[3] & (|c[2:1])});
        prev_len = exp;
    endtask : t_cycle

    task automatic t_results;
        int n;
        prev_len = 0;
        wr_reg(8'h00, 16'h0007);
        wr_reg(8'h04, 16'h000a);
        feed(3'b001, 12'h4b0);
        feed(3'b010, 12'h12c);
        feed(3'b100, 12'hed4);
        span(n);
        rd_reg(8'h10, 16'h04b0);
        rd_reg(8'h14, 16'h0122);
        rd_reg(8'h18, 16'h0ede);
        wr_reg(8'h04, 16'h0080);
        feed(3'b010, 12'h12c);
        feed(3'b100, 12'h7ff);
        span(n);
        rd_reg(8'h14, 16'h01ac);
        rd_reg(8'h18, 16'h07ff);
    endtask : t_results

    // The local register is held while shifted out; the remote one still updates
    task automatic t_xfer;
        int n;
        wr_reg(8'h04, 16'h0000);
        xfer_sel <= 2'h0;
        xfer_busy <= 1'b1;
        feed(3'b001, 12'h0c8);
        feed(3'b010, 12'h320);
        span(n);
        rd_reg(8'h10, 16'h04b0);
        rd_reg(8'h14, 16'h0320);
        @(posedge clk_sys);
        xfer_busy <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd_reg(8'h10, 16'h00c8);
    endtask : t_xfer

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // Main sequence; the delay case runs last as it stretches every later cycle
    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        t_regs();
        t_cycle(16'h0001, 16'h0000);
        t_cycle(16'h0002, 16'h0000);
        t_cycle(16'h000c, 16'h0000);
        t_cycle(16'h0003, 16'h0000);
        t_cycle(16'h000b, 16'h0000);
        t_cycle(16'h0006, 16'h0000);
        t_cycle(16'h000e, 16'h0000);
        t_cycle(16'h0007, 16'h0000);
        t_cycle(16'h000f, 16'h0000);
        t_results();
        t_xfer();
        t_cycle(16'h0001, 16'h0007);
        end_sim();
    end

    // Watchdog: the whole run needs well under ten thousand clocks
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
endmodule : tmseq_tb_top
